// ---- logic/sad_decoder.sv ----
// module: memory address decoder and secondary error forwarding of the host bridge
// Functional notes
// - claim accesses at or above 4 GB; writes dropped, reads return zeros.
// - no dual address cycles; upper address bits never reach PCI or graphics.
// - thirteen read/write controlled ranges plus one DRAM-or-PCI range below 1 MB.
// - lowest 512 KB always goes to DRAM.
// - 080000h 128-KB range goes to DRAM unless the hole control marks it.
// - video buffer ignores attributes; goes to PCI or graphics only.
// - VGA enable steers video buffer for processor, PCI and graphics origins.
// - expansion area is eight 16-KB segments with four read/write states.
// - disabled expansion segments go to PCI, DRAM not relocated.
// - extended BIOS is four 16-KB segments with read and write attributes.
// - system BIOS one 64-KB segment, disabled after reset, goes to PCI.
// - 1 MB to top of memory goes to DRAM except the programmed hole.
// - DRAM behind an enabled hole is never relocated.
// - above top of DRAM goes to PCI; window to graphics, aperture to DRAM.
// - APIC configuration range decodes to PCI.
// - gap between APIC range and high BIOS always goes to PCI.
// - forward graphics system error to SERR when both enables set.
// - graphics parity always generated regardless of reporting enable.
// - parity response enable gates graphics parity error reporting.
// - address parity errors reach SERR when parity and command enables set.
`timescale 1ns/1ns
`default_nettype none
module sad_decoder (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // host request and registered decode result
  input wire logic I_REQ_VALID,
  input wire sad_pkg::sad_req_s I_REQ,
  input wire sad_pkg::sad_map_s I_MAP,
  output logic O_RSP_VALID,
  output sad_pkg::sad_rsp_s O_RSP,
  output logic [31:0] O_FWD_ADDR,
  // requests arriving from PCI or graphics into the video buffer
  input wire logic I_PEER_VGA_VALID,
  output logic O_PEER_VGA_TO_GFX,
  // secondary bridge control register write port
  input wire logic I_SECONDARY_BRIDGE_CONTROL_WE,
  input wire logic [15:0] I_SECONDARY_BRIDGE_CONTROL_WDATA,
  output logic [15:0] O_SECONDARY_BRIDGE_CONTROL,
  input wire logic I_SERR_FWD_EN,
  // compatibility attribute write port: index 0..12
  input wire logic I_ATTR_WE,
  input wire logic [3:0] I_ATTR_IDX,
  input wire logic [1:0] I_ATTR_WDATA,
  input wire logic I_DOS_HOLE,
  // graphics side error pins
  input wire logic I_GFX_SERR_N,
  input wire logic I_GFX_ADDR_PERR,
  input wire logic I_GFX_DATA_PERR,
  input wire logic [31:0] I_GFX_DATA,
  output logic O_GFX_PAR,
  output logic O_GFX_PERR_N,
  output logic O_PCI_SERR_N
);
  import sad_pkg::*;

  // ==========================================================
  // registers
  logic [15:0] secondary_bridge_control_q;
  logic [1:0] attr_q [0:ATTR_CNT-1];
  logic [2:0] graphics_system_error_in_sync_q;
  logic graphics_system_error_in_lvl_q;
  logic rsp_valid_q;
  sad_rsp_s rsp_q;
  logic [31:0] fwd_addr_q;
  logic perr_q;
  logic serr_q;
  logic par_q;

  // decode a 16-KB segment index inside a 64-KB or 128-KB area
  function automatic logic [SEG_W-1:0] seg_of(input logic [31:0] a);
    seg_of = a[SEG_LSB +: SEG_W];
  endfunction : seg_of

  // inclusive 1-MB granular range check
  function automatic logic in_mb(input logic [31:0] a, input logic [MB_W-1:0] b,
                                 input logic [MB_W-1:0] l);
    in_mb = (a[MB_LSB +: MB_W] >= b) && (a[MB_LSB +: MB_W] <= l);
  endfunction : in_mb

  // attribute check: read or write enable for the given access
  function automatic logic attr_hit(input logic [1:0] at, input logic wr);
    attr_hit = wr ? at[ATTR_WE] : at[ATTR_RE];
  endfunction : attr_hit

  // ==========================================================
  // bridge control register, writable bits only
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      secondary_bridge_control_q <= SECONDARY_BRIDGE_CONTROL_RST;
    end else if (I_SECONDARY_BRIDGE_CONTROL_WE) begin
      secondary_bridge_control_q <= I_SECONDARY_BRIDGE_CONTROL_WDATA & SECONDARY_BRIDGE_CONTROL_WMASK;
    end
  end
  assign O_SECONDARY_BRIDGE_CONTROL = secondary_bridge_control_q;

  // compatibility attributes: 8 expansion, 4 extended BIOS, 1 system BIOS
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < ATTR_CNT; i++) begin
        attr_q[i] <= ATTR_RST;
      end
    end else if (I_ATTR_WE && (I_ATTR_IDX < ATTR_IDX_END)) begin
      attr_q[I_ATTR_IDX] <= I_ATTR_WDATA;
    end
  end

  // ==========================================================
  // combinational routing decision
  sad_rsp_s dec_d;
  logic [31:0] a32;
  logic vga_gfx;
  assign a32 = I_REQ.addr[31:0];
  assign vga_gfx = secondary_bridge_control_q[BC_VGA_EN];
  // extended BIOS segments use the attribute slots after the eight expansion ones
  logic [3:0] ebios_idx;
  assign ebios_idx = ATTR_EBIOS_IDX | {2'h0, a32[SEG_LSB +: EBIOS_SEG_W]};

  // fixed ranges are tested ahead of the programmable ones, so a top of memory
  // set too high can never pull the APIC range or the high BIOS into DRAM
  always_comb begin
    dec_d.dst = SAD_DST_PCI;
    dec_d.rd_zero = 1'b0;
    if (I_REQ.addr >= ADDR_4G) begin
      dec_d.dst = SAD_DST_LOCAL;
      dec_d.rd_zero = !I_REQ.write;
    end else if (a32 < DOS_LOW_END) begin
      dec_d.dst = SAD_DST_DRAM;
    end else if (a32 < DOS_HI_END) begin
      dec_d.dst = I_DOS_HOLE ? SAD_DST_PCI : SAD_DST_DRAM;
    end else if (a32 < VGA_END) begin
      dec_d.dst = vga_gfx ? SAD_DST_GFX : SAD_DST_PCI;
    end else if (a32 < EXP_END) begin
      if (attr_hit(attr_q[seg_of(a32)], I_REQ.write)) begin
        dec_d.dst = SAD_DST_DRAM;
      end
    end else if (a32 < EBIOS_END) begin
      if (attr_hit(attr_q[ebios_idx], I_REQ.write)) begin
        dec_d.dst = SAD_DST_DRAM;
      end
    end else if (a32 < ONE_MB) begin
      if (attr_hit(attr_q[ATTR_SBIOS_IDX], I_REQ.write)) begin
        dec_d.dst = SAD_DST_DRAM;
      end
    end else if ((a32 >= APIC_BASE && a32 < APIC_IO_END) ||
                 (a32 >= APIC_LOC_BASE && a32 < APIC_LOC_END)) begin
      dec_d.dst = SAD_DST_PCI;
    end else if (a32 >= APIC_BASE) begin
      dec_d.dst = SAD_DST_PCI;
    end else if (a32[MB_LSB +: MB_W] < I_MAP.tom_mb) begin
      if (I_MAP.hole_en && in_mb(a32, I_MAP.hole_base_mb, I_MAP.hole_lim_mb)) begin
        dec_d.dst = SAD_DST_PCI;
      end else begin
        dec_d.dst = SAD_DST_DRAM;
      end
    end else if (I_MAP.win_en && in_mb(a32, I_MAP.win_base_mb, I_MAP.win_lim_mb)) begin
      dec_d.dst = SAD_DST_GFX;
    end else if (I_MAP.ap_en && in_mb(a32, I_MAP.ap_base_mb, I_MAP.ap_lim_mb)) begin
      dec_d.dst = SAD_DST_DRAM;
    end
  end

  // ==========================================================
  // registered result, one cycle after the request
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '{dst: SAD_DST_PCI, rd_zero: 1'b0};
      fwd_addr_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= I_REQ_VALID;
      if (I_REQ_VALID) begin
        rsp_q <= dec_d;
        fwd_addr_q <= a32;
      end
    end
  end
  assign O_RSP_VALID = rsp_valid_q;
  assign O_RSP = rsp_q;
  assign O_FWD_ADDR = fwd_addr_q;

  // video buffer steering for accesses from the peer buses
  assign O_PEER_VGA_TO_GFX = I_PEER_VGA_VALID & vga_gfx;

  // ==========================================================
  // graphics system error pin synchroniser
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      graphics_system_error_in_sync_q <= '1;
    end else begin
      graphics_system_error_in_sync_q <= {graphics_system_error_in_sync_q[1:0], I_GFX_SERR_N};
    end
  end

  // accepted pin level: a change counts only once stages two and three agree,
  // so a glitch caught by the first stage never reaches the primary bus
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      graphics_system_error_in_lvl_q <= 1'b1;
    end else if (graphics_system_error_in_sync_q[2] == graphics_system_error_in_sync_q[1]) begin
      graphics_system_error_in_lvl_q <= graphics_system_error_in_sync_q[2];
    end
  end

  // error forwarding and parity
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      perr_q <= 1'b0;
      serr_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      par_q <= ^I_GFX_DATA;
      perr_q <= secondary_bridge_control_q[BC_PERR_EN] & (I_GFX_ADDR_PERR | I_GFX_DATA_PERR);
      serr_q <= I_SERR_FWD_EN &
                ((secondary_bridge_control_q[BC_SERR_EN] & ~graphics_system_error_in_lvl_q) |
                 (secondary_bridge_control_q[BC_PERR_EN] & I_GFX_ADDR_PERR));
    end
  end
  assign O_GFX_PAR = par_q;
  assign O_GFX_PERR_N = ~perr_q;
  assign O_PCI_SERR_N = ~serr_q;

  // ==========================================================
  // checks
  chk_above_4g_local: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= ADDR_4G |=> O_RSP.dst == SAD_DST_LOCAL &&
      O_RSP.rd_zero == !$past(I_REQ.write))
    else $error("access above 4 GB not terminated locally");
  chk_dos_low_dram: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr < {4'h0, DOS_LOW_END} |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("low 512 KB not routed to DRAM");
  chk_dos_hole: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= {4'h0, DOS_LOW_END} && I_REQ.addr < {4'h0, DOS_HI_END}
      |=> O_RSP.dst == ($past(I_DOS_HOLE) ? SAD_DST_PCI : SAD_DST_DRAM))
    else $error("dos hole routing wrong");
  chk_vga_never_dram: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= {4'h0, DOS_HI_END} && I_REQ.addr < {4'h0, VGA_END}
      |=> O_RSP.dst == ($past(vga_gfx) ? SAD_DST_GFX : SAD_DST_PCI))
    else $error("video buffer routed wrong");
  chk_bios_reset_pci: assert property (@(posedge I_MCLK)
    $rose(I_NRST) |-> attr_q[ATTR_SBIOS_IDX] == ATTR_RST)
    else $error("system BIOS attributes not disabled after reset");
  chk_gap_to_pci: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= {4'h0, APIC_BASE} && I_REQ.addr < ADDR_4G
      |=> O_RSP.dst == SAD_DST_PCI)
    else $error("APIC or gap range not routed to PCI");
  chk_serr_forward: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !graphics_system_error_in_lvl_q && secondary_bridge_control_q[BC_SERR_EN] && I_SERR_FWD_EN
      |=> !O_PCI_SERR_N)
    else $error("graphics system error not forwarded");
  chk_perr_gate: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !secondary_bridge_control_q[BC_PERR_EN] |=> O_GFX_PERR_N || $past(secondary_bridge_control_q[BC_PERR_EN], 1) == 1'b1)
    else $error("parity error reported while disabled");
  chk_parity_gen: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    1'b1 |=> O_GFX_PAR == ^$past(I_GFX_DATA))
    else $error("graphics parity not generated");

  // request classes above 1 MB and below the APIC range, for the routing checks
  logic cls_ext;
  logic cls_below_tom;
  logic cls_hole;
  logic cls_win;
  logic cls_ap;
  assign cls_ext = I_REQ_VALID && I_REQ.addr >= {4'h0, ONE_MB} &&
                   I_REQ.addr < {4'h0, APIC_BASE};
  assign cls_below_tom = a32[MB_LSB +: MB_W] < I_MAP.tom_mb;
  assign cls_hole = I_MAP.hole_en && in_mb(a32, I_MAP.hole_base_mb, I_MAP.hole_lim_mb);
  assign cls_win = I_MAP.win_en && in_mb(a32, I_MAP.win_base_mb, I_MAP.win_lim_mb);
  assign cls_ap = I_MAP.ap_en && in_mb(a32, I_MAP.ap_base_mb, I_MAP.ap_lim_mb);

  // routing checks for the attribute areas and the extended memory
  chk_exp_read: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && !I_REQ.write && I_REQ.addr >= {4'h0, VGA_END} &&
      I_REQ.addr < {4'h0, EXP_END} && attr_q[a32[SEG_LSB +: SEG_W]][ATTR_RE]
      |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("enabled expansion read not routed to DRAM");
  chk_exp_disabled: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= {4'h0, VGA_END} && I_REQ.addr < {4'h0, EXP_END} &&
      attr_q[a32[SEG_LSB +: SEG_W]] == ATTR_RST |=> O_RSP.dst == SAD_DST_PCI)
    else $error("disabled expansion segment not routed to PCI");
  chk_ebios_write: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.write && I_REQ.addr >= {4'h0, EXP_END} &&
      I_REQ.addr < {4'h0, EBIOS_END} && attr_q[ebios_idx][ATTR_WE]
      |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("enabled extended BIOS write not routed to DRAM");
  chk_bios_shadow: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && !I_REQ.write && I_REQ.addr >= {4'h0, EBIOS_END} &&
      I_REQ.addr < {4'h0, ONE_MB} && attr_q[ATTR_SBIOS_IDX][ATTR_RE]
      |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("shadowed system BIOS read not routed to DRAM");
  chk_main_dram: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    cls_ext && cls_below_tom && !cls_hole |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("main memory access not routed to DRAM");
  chk_hole_pci: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    cls_ext && cls_below_tom && cls_hole |=> O_RSP.dst == SAD_DST_PCI)
    else $error("main memory hole not routed to PCI");
  chk_window_gfx: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    cls_ext && !cls_below_tom && cls_win |=> O_RSP.dst == SAD_DST_GFX)
    else $error("graphics window not routed to graphics port");
  chk_aperture_dram: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    cls_ext && !cls_below_tom && !cls_win && cls_ap |=> O_RSP.dst == SAD_DST_DRAM)
    else $error("graphics aperture not routed to DRAM");
  chk_above_tom_pci: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    cls_ext && !cls_below_tom && !cls_win && !cls_ap |=> O_RSP.dst == SAD_DST_PCI)
    else $error("access above top of memory not routed to PCI");
  chk_apic_pci: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID && I_REQ.addr >= {4'h0, APIC_BASE} && I_REQ.addr < {4'h0, APIC_IO_END}
      |=> O_RSP.dst == SAD_DST_PCI)
    else $error("APIC configuration range not routed to PCI");
  chk_fwd_low_bits: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_REQ_VALID |=> O_FWD_ADDR == $past(I_REQ.addr[31:0]))
    else $error("forwarded address differs from low request bits");
  chk_rsp_pulse: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    1'b1 |=> O_RSP_VALID == $past(I_REQ_VALID))
    else $error("decode result not given exactly once per request");
  chk_peer_vga_gfx: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_PEER_VGA_VALID && O_SECONDARY_BRIDGE_CONTROL[BC_VGA_EN] |-> O_PEER_VGA_TO_GFX)
    else $error("peer video access not steered to graphics");
  chk_peer_vga_pci: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !O_SECONDARY_BRIDGE_CONTROL[BC_VGA_EN] |-> !O_PEER_VGA_TO_GFX)
    else $error("peer video access steered to graphics while disabled");

  // error path checks
  chk_addr_perr_serr: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_GFX_ADDR_PERR && secondary_bridge_control_q[BC_PERR_EN] && I_SERR_FWD_EN |=> !O_PCI_SERR_N)
    else $error("address parity error not reported on system error");
  chk_serr_needs_cmd: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !I_SERR_FWD_EN |=> O_PCI_SERR_N)
    else $error("system error driven without command enable");
  chk_perr_report: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    secondary_bridge_control_q[BC_PERR_EN] && (I_GFX_ADDR_PERR || I_GFX_DATA_PERR) |=> !O_GFX_PERR_N)
    else $error("enabled parity error not reported");

endmodule : sad_decoder
`default_nettype wire

// ---- logic/sad_pkg.sv ----
// package: constants and types of the system address decoder
package sad_pkg;

  // ==========================================================
  // address space layout
  localparam logic [35:0] ADDR_4G = 36'h1_0000_0000;
  localparam logic [31:0] DOS_LOW_END = 32'h0008_0000;
  localparam logic [31:0] DOS_HI_END = 32'h000A_0000;
  localparam logic [31:0] VGA_END = 32'h000C_0000;
  localparam logic [31:0] EXP_END = 32'h000E_0000;
  localparam logic [31:0] EBIOS_END = 32'h000F_0000;
  localparam logic [31:0] ONE_MB = 32'h0010_0000;
  localparam logic [31:0] APIC_BASE = 32'hFEC0_0000;
  localparam logic [31:0] APIC_IO_END = 32'hFED0_0000;
  localparam logic [31:0] APIC_LOC_BASE = 32'hFEE0_0000;
  localparam logic [31:0] APIC_LOC_END = 32'hFEF0_0000;
  localparam logic [31:0] HBIOS_BASE = 32'hFFE0_0000;
  // segment index bits inside the compatibility area (16-KB steps)
  localparam int SEG_LSB = 14;
  localparam int SEG_W = 3;
  // 1-MB granular window decode
  localparam int MB_LSB = 20;
  localparam int MB_W = 12;

  // ==========================================================
  // bridge control fields and reset values
  localparam int BC_PERR_EN = 0;
  localparam int BC_SERR_EN = 1;
  localparam int BC_VGA_EN = 3;
  localparam logic [15:0] SECONDARY_BRIDGE_CONTROL_RST = 16'h0000;
  localparam logic [15:0] SECONDARY_BRIDGE_CONTROL_WMASK = 16'h000B;
  // compatibility attributes: bit0 read enable, bit1 write enable
  localparam logic [1:0] ATTR_RST = 2'h0;
  localparam int ATTR_RE = 0;
  localparam int ATTR_WE = 1;
  // attribute slots: eight expansion, four extended BIOS, one system BIOS
  localparam int ATTR_CNT = 13;
  localparam logic [3:0] ATTR_EBIOS_IDX = 4'h8;
  localparam logic [3:0] ATTR_SBIOS_IDX = 4'hC;
  localparam logic [3:0] ATTR_IDX_END = 4'hD;
  localparam int EBIOS_SEG_W = 2;

  // ==========================================================
  // destinations of an access
  typedef enum logic [2:0] {
    SAD_DST_DRAM,
    SAD_DST_PCI,
    SAD_DST_GFX,
    SAD_DST_LOCAL
  } sad_dst_e;

  // host request carried into the decoder
  typedef struct packed {
    logic [35:0] addr;
    logic write;
  } sad_req_s;

  // decoding result
  typedef struct packed {
    sad_dst_e dst;
    logic rd_zero;
  } sad_rsp_s;

  // address range configuration, 1-MB granular
  typedef struct packed {
    logic [11:0] tom_mb;
    logic hole_en;
    logic [11:0] hole_base_mb;
    logic [11:0] hole_lim_mb;
    logic win_en;
    logic [11:0] win_base_mb;
    logic [11:0] win_lim_mb;
    logic ap_en;
    logic [11:0] ap_base_mb;
    logic [11:0] ap_lim_mb;
  } sad_map_s;

endpackage : sad_pkg

// ---- tb/sad_gfx_agent.sv ----
// file: graphics-side agent model driving error pins and a changing data bus
`timescale 1ns/1ns
`default_nettype none
module sad_gfx_agent (
  // clock, reset and commands from the bench
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_serr,
  input wire logic i_aperr,
  input wire logic i_dperr,
  // pins toward the decoder
  output logic o_serr_n,
  output logic o_aperr,
  output logic o_dperr,
  output logic [31:0] o_data
);
  // pins change just after the rising edge; system error is active low, driven high when released
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serr_n <= 1'b1;
      o_aperr <= 1'b0;
      o_dperr <= 1'b0;
      o_data <= 32'hA5C3_0F01;
    end else begin
      o_serr_n <= ~i_serr;
      o_aperr <= i_aperr;
      o_dperr <= i_dperr;
      o_data <= {o_data[30:0], ~(o_data[31] ^ o_data[20])}; // new pattern every cycle
    end
  end
endmodule : sad_gfx_agent
`default_nettype wire

// ---- tb/system_address_decoder_bench.sv ----
// file: self-checking bench of the system address decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module system_address_decoder_bench;
  import sad_pkg::*;
  logic clk, nrst, req_valid, peer_vga, bc_we, serr_fwd, attr_we, dos_hole, p;
  logic g_serr, g_aperr, g_dperr, serr_n, aperr, dperr, peer_gfx, rsp_valid, par, perr_n, pserr_n;
  logic [15:0] bc_wdata, secondary_bridge_control;
  logic [3:0] attr_idx;
  logic [1:0] attr_wdata;
  logic [31:0] gdata, fwd;
  sad_req_s req;
  sad_map_s map;
  sad_rsp_s rsp;
  int num_errors, check_count;

  sad_decoder sad_decoder_i (.I_MCLK(clk), .I_NRST(nrst), .I_REQ_VALID(req_valid), .I_REQ(req),
    .I_MAP(map), .O_RSP_VALID(rsp_valid), .O_RSP(rsp), .O_FWD_ADDR(fwd),
    .I_PEER_VGA_VALID(peer_vga), .O_PEER_VGA_TO_GFX(peer_gfx), .I_SECONDARY_BRIDGE_CONTROL_WE(bc_we),
    .I_SECONDARY_BRIDGE_CONTROL_WDATA(bc_wdata), .O_SECONDARY_BRIDGE_CONTROL(secondary_bridge_control), .I_SERR_FWD_EN(serr_fwd), .I_ATTR_WE(attr_we),
    .I_ATTR_IDX(attr_idx), .I_ATTR_WDATA(attr_wdata), .I_DOS_HOLE(dos_hole),
    .I_GFX_SERR_N(serr_n), .I_GFX_ADDR_PERR(aperr), .I_GFX_DATA_PERR(dperr), .I_GFX_DATA(gdata),
    .O_GFX_PAR(par), .O_GFX_PERR_N(perr_n), .O_PCI_SERR_N(pserr_n));
  sad_gfx_agent sad_gfx_agent_i (.i_clk(clk), .i_nrst(nrst), .i_serr(g_serr), .i_aperr(g_aperr),
    .i_dperr(g_dperr), .o_serr_n(serr_n), .o_aperr(aperr), .o_dperr(dperr), .o_data(gdata));

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    test_done();
  end

  // ==========================================================
  // access tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // one host access, answer checked at the falling edge after the rising edge that takes it
  task automatic acc(input logic [35:0] a, input logic w, input sad_dst_e d);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{addr: a, write: w};
    @(negedge clk);
    req_valid = 1'b0;
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("dst", d, rsp.dst)
    `CHK("rd_zero", (d == SAD_DST_LOCAL) && !w, rsp.rd_zero)
    `CHK("fwd_addr", a[31:0], fwd)
  endtask : acc
  task automatic bc_wr(input logic [15:0] v);
    @(negedge clk);
    bc_we = 1'b1;
    bc_wdata = v;
    @(negedge clk);
    bc_we = 1'b0;
  endtask : bc_wr
  task automatic attr_wr(input logic [3:0] i, input logic [1:0] v);
    @(negedge clk);
    attr_we = 1'b1;
    attr_idx = i;
    attr_wdata = v;
    @(negedge clk);
    attr_we = 1'b0;
  endtask : attr_wr
  // error stimulus for eight cycles, then released; records whether each pin went low
  task automatic err(input logic [15:0] bc, input logic f, s, ap, dp, ep, es);
    logic sp;
    logic ss;
    bc_wr(bc);
    serr_fwd = f;
    g_serr = s;
    g_aperr = ap;
    g_dperr = dp;
    sp = 1'b0;
    ss = 1'b0;
    repeat (8) begin
      @(negedge clk);
      sp |= (perr_n === 1'b0);
      ss |= (pserr_n === 1'b0);
    end
    g_serr = 1'b0;
    g_aperr = 1'b0;
    g_dperr = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("perr_seen", ep, sp)
    `CHK("serr_seen", es, ss)
    `CHK("perr_idle", 1'b1, perr_n)
    `CHK("serr_idle", 1'b1, pserr_n)
  endtask : err
  // base of compatibility segment i; index 8 lands on E0000h, 12 on F0000h
  function automatic logic [35:0] seg(input int i);
    return (i < 12) ? 36'h0_000C_0000 + 36'(i) * 36'h0_0000_4000 : 36'h0_000F_0000;
  endfunction : seg

  // ==========================================================
  // test sequence
  initial begin
    {nrst, req_valid, peer_vga, bc_we, serr_fwd, attr_we, dos_hole} = '0;
    {g_serr, g_aperr, g_dperr, bc_wdata, attr_idx, attr_wdata} = '0;
    req = '0;
    map = '{tom_mb: 12'h040, hole_en: 1'b1, hole_base_mb: 12'h010, hole_lim_mb: 12'h011,
      win_en: 1'b1, win_base_mb: 12'hE00, win_lim_mb: 12'hE0F,
      ap_en: 1'b1, ap_base_mb: 12'hD00, ap_lim_mb: 12'hD3F};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    `CHK("secondary_bridge_control_rst", 16'h0000, secondary_bridge_control)
    `CHK("perr_rst", 1'b1, perr_n)
    `CHK("serr_rst", 1'b1, pserr_n)
    $display("test reset done");
    acc(36'h0_000F_8000, 1'b0, SAD_DST_PCI);
    acc(36'h1_0000_0040, 1'b0, SAD_DST_LOCAL);
    acc(36'hF_1234_5678, 1'b1, SAD_DST_LOCAL);
    acc(36'h0_0007_FFFC, 1'b1, SAD_DST_DRAM);
    acc(36'h0_0008_0000, 1'b0, SAD_DST_DRAM);
    acc(36'h0_000A_0000, 1'b0, SAD_DST_PCI);
    acc(36'h0_0010_0000, 1'b0, SAD_DST_DRAM);
    acc(36'h0_0100_0000, 1'b1, SAD_DST_PCI);
    acc(36'h0_0120_0000, 1'b0, SAD_DST_DRAM);
    acc(36'h0_03FF_FFFC, 1'b0, SAD_DST_DRAM);
    acc(36'h0_0400_0000, 1'b0, SAD_DST_PCI);
    acc(36'h0_E0F0_0000, 1'b1, SAD_DST_GFX);
    acc(36'h0_D3F0_0000, 1'b0, SAD_DST_DRAM);
    acc(36'h0_FEC0_5000, 1'b0, SAD_DST_PCI);
    acc(36'h0_FEE0_0000, 1'b1, SAD_DST_PCI);
    acc(36'h0_FEF0_0000, 1'b0, SAD_DST_PCI);
    dos_hole = 1'b1;
    acc(36'h0_0009_FFFC, 1'b0, SAD_DST_PCI);
    acc(36'h0_0007_0000, 1'b0, SAD_DST_DRAM);
    dos_hole = 1'b0;
    $display("test decode done");
    bc_wr(16'hFFFF);
    `CHK("secondary_bridge_control_mask", 16'h000B, secondary_bridge_control)
    peer_vga = 1'b1;
    #1 `CHK("peer_gfx", 1'b1, peer_gfx)
    acc(36'h0_000A_0000, 1'b1, SAD_DST_GFX);
    bc_wr(16'h0000);
    #1 `CHK("peer_pci", 1'b0, peer_gfx)
    peer_vga = 1'b0;
    attr_wr(4'hD, 2'h3);
    acc(36'h0_000F_0000, 1'b0, SAD_DST_PCI);
    for (int i = 0; i < 13; i++) begin
      for (int a = 0; a < 4; a++) begin
        attr_wr(4'(i), 2'(a));
        acc(seg(i), 1'b0, a[0] ? SAD_DST_DRAM : SAD_DST_PCI);
        acc(seg(i) + 36'h3FFC, 1'b1, a[1] ? SAD_DST_DRAM : SAD_DST_PCI);
      end
    end
    acc(36'h0_000B_FFFC, 1'b0, SAD_DST_PCI);
    $display("test attributes done");
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    acc(36'h0_000F_0000, 1'b0, SAD_DST_PCI);
    acc(36'h0_000C_0000, 1'b1, SAD_DST_PCI);
    $display("test second reset done");
    repeat (8) begin
      @(negedge clk);
      p = ^gdata;
      @(negedge clk);
      `CHK("gfx_par", p, par)
    end
    err(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    err(16'h0002, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    err(16'h0002, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    err(16'h0001, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    err(16'h0001, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    err(16'h0001, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    $display("test errors done");
    test_done();
  end
endmodule : system_address_decoder_bench
`default_nettype wire
